// file: inc/dcp_pkg.sv
// constants and types for the dram clock-enable power-state controller
//
// What this block does
// - cke low only after mode-register delays
// - hold cke for one cycle past the minimum pulse (cke_min plus one)
// - power-down entry/exit edges carry nop/deselect
// - self-refresh exit edge carries nop/deselect
// - self-refresh entry only from idle with refresh
// - no self-refresh entry during read/write
// - idle means closed, no burst, timings met except the write wait
// - nop/deselect only during exit-to-command delay
// - reads and odt wait for dll-lock delay
// - writes wait 512 cycles after self-refresh
// - only legal cke and command combinations
// - commands decoded from strobes and cke
package dcp_pkg;

  // ****************************************************
  // command encodings {cs_n, ras_n, cas_n, we_n}
  // ****************************************************
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'hF;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_WR  = 4'h4;

  // ****************************************************
  // counts and reset values
  // ****************************************************
  localparam int unsigned CNT_W        = 12;
  localparam logic [CNT_W-1:0] WR_AFTER_SRX_NCK = 12'h200;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;
  localparam logic [CNT_W-1:0] DEF_CKE_MIN   = 12'h003;
  localparam logic [CNT_W-1:0] DEF_MOD       = 12'h00C;
  localparam logic [CNT_W-1:0] DEF_XP        = 12'h003;
  localparam logic [CNT_W-1:0] DEF_XS        = 12'h010;
  localparam logic [CNT_W-1:0] DEF_XSDLL     = 12'h200;
  localparam logic [CNT_W-1:0] DEF_PD_MAX    = 12'h100;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_APD    = 5'h02,
    ST_PPD    = 5'h04,
    ST_SR     = 5'h08,
    ST_EXIT   = 5'h10
  } dcp_state_type;

  typedef enum logic [2:0] {
    REQ_NONE = 3'h0,
    REQ_PDE  = 3'h1,
    REQ_SRE  = 3'h2,
    REQ_EXIT = 3'h3,
    REQ_CMD  = 3'h4
  } dcp_req_type;

  // pins driven to the memory
  typedef struct packed {
    logic       cke;
    logic [3:0] cmd;
    logic       odt;
  } dcp_pins_type;

  // programmable delays, in link cycles
  typedef struct packed {
    logic [CNT_W-1:0] cke_min;
    logic [CNT_W-1:0] mod;
    logic [CNT_W-1:0] xp;
    logic [CNT_W-1:0] xs;
    logic [CNT_W-1:0] xsdll;
    logic [CNT_W-1:0] pd_max;
  } dcp_timing_type;

endpackage : dcp_pkg

// file: logic/dcp_ctrl.sv
// host-side clock-enable power-state controller for a ddr memory
`timescale 1ns/1ns
module dcp_ctrl (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_link_clk,
  input  wire logic                  i_req_tgl,
  input  wire dcp_pkg::dcp_req_type  i_req_kind,
  input  wire logic [3:0]            i_req_cmd,
  input  wire logic                  i_req_odt,
  input  wire logic                  i_banks_open,
  input  wire logic                  i_busy,
  input  wire dcp_pkg::dcp_timing_type i_timing,
  output logic                       o_ack_tgl,
  output logic                       o_refused,
  output dcp_pkg::dcp_state_type     o_state,
  output logic                       o_dram_ck,
  output dcp_pkg::dcp_pins_type      o_dram
);

  // ****************************************************
  // core domain: request toggle, ack sync
  // ****************************************************
  typedef struct packed {
    logic                  ack_s1;
    logic                  ack_s2;
    logic                  ack_seen;
    logic                  ack_tgl;
    logic                  refused;
    logic                  st_s1;
    logic                  st_s2;
    logic                  st_seen;
    dcp_pkg::dcp_state_type state;
  } dcp_core_type;

  dcp_core_type core_reg;
  dcp_core_type core_next;

  // ****************************************************
  // link domain: pins, state, counters
  // ****************************************************
  typedef struct packed {
    logic                    req_s1;
    logic                    req_s2;
    logic                    req_seen;
    logic                    done_tgl;
    logic                    ref_ok;
    logic                    st_tgl;
    logic                    banks_s1;
    logic                    banks_s2;
    logic                    busy_s1;
    logic                    busy_s2;
    dcp_pkg::dcp_state_type  state;
    dcp_pkg::dcp_pins_type   pins;
    logic [dcp_pkg::CNT_W-1:0] cke_cnt;
    logic [dcp_pkg::CNT_W-1:0] mod_cnt;
    logic [dcp_pkg::CNT_W-1:0] xs_cnt;
    logic [dcp_pkg::CNT_W-1:0] dll_cnt;
    logic [dcp_pkg::CNT_W-1:0] wr_cnt;
    logic [dcp_pkg::CNT_W-1:0] pd_cnt;
  } dcp_link_type;

  dcp_link_type link_reg;
  dcp_link_type link_next;

  function automatic logic [dcp_pkg::CNT_W-1:0] dec_cnt(input logic [dcp_pkg::CNT_W-1:0] v);
    dec_cnt = (v == dcp_pkg::CNT_ZERO) ? v : v - dcp_pkg::CNT_ONE;
  endfunction : dec_cnt

  function automatic logic is_idle_cmd(input logic [3:0] c);
    is_idle_cmd = c[3] | (c == dcp_pkg::CMD_NOP);
  endfunction : is_idle_cmd

  // request fields are held stable by the core side until ack
  logic go;
  logic exit_ok;
  logic cmd_ok;
  assign go      = link_reg.req_s2 != link_reg.req_seen;
  assign exit_ok = link_reg.cke_cnt == dcp_pkg::CNT_ZERO;

  always_comb begin
    cmd_ok = (link_reg.state == dcp_pkg::ST_NORMAL) && (link_reg.xs_cnt == dcp_pkg::CNT_ZERO);
    if ((i_req_cmd == dcp_pkg::CMD_RD || i_req_odt) && link_reg.dll_cnt != dcp_pkg::CNT_ZERO) begin
      cmd_ok = 1'b0;
    end
    if (i_req_cmd == dcp_pkg::CMD_WR && link_reg.wr_cnt != dcp_pkg::CNT_ZERO) begin
      cmd_ok = 1'b0;
    end
    if (i_req_cmd == dcp_pkg::CMD_MRS && link_reg.mod_cnt != dcp_pkg::CNT_ZERO) begin
      cmd_ok = 1'b0;
    end
  end

  always_comb begin
    link_next          = link_reg;
    link_next.req_s1   = i_req_tgl;
    link_next.req_s2   = link_reg.req_s1;
    link_next.cke_cnt  = dec_cnt(link_reg.cke_cnt);
    link_next.mod_cnt  = dec_cnt(link_reg.mod_cnt);
    link_next.xs_cnt   = dec_cnt(link_reg.xs_cnt);
    link_next.dll_cnt  = dec_cnt(link_reg.dll_cnt);
    link_next.wr_cnt   = dec_cnt(link_reg.wr_cnt);
    link_next.banks_s1 = i_banks_open;
    link_next.banks_s2 = link_reg.banks_s1;
    link_next.busy_s1  = i_busy;
    link_next.busy_s2  = link_reg.busy_s1;
    link_next.pins.cmd = dcp_pkg::CMD_DES;
    link_next.pins.odt = 1'b0;
    case (link_reg.state)
      dcp_pkg::ST_NORMAL: begin
        if (!link_reg.pins.cke) begin
          // first cycle out of reset: raise cke under nop
          link_next.pins.cke = 1'b1;
          link_next.pins.cmd = dcp_pkg::CMD_NOP;
          link_next.cke_cnt  = i_timing.cke_min;
        end else if (go) begin
          link_next.req_seen = link_reg.req_s2;
          link_next.done_tgl = ~link_reg.done_tgl;
          link_next.ref_ok   = 1'b1;
          case (i_req_kind)
            dcp_pkg::REQ_PDE: begin
              // cke fall only once mode delay and pulse time are met
              if (exit_ok && link_reg.mod_cnt == dcp_pkg::CNT_ZERO && link_reg.xs_cnt == dcp_pkg::CNT_ZERO) begin
                link_next.pins.cke = 1'b0;
                link_next.pins.cmd = dcp_pkg::CMD_NOP;
                link_next.cke_cnt  = i_timing.cke_min;
                link_next.pd_cnt   = i_timing.pd_max;
                link_next.state    = link_reg.banks_s2 ? dcp_pkg::ST_APD : dcp_pkg::ST_PPD;
              end else begin
                link_next.ref_ok = 1'b0;
              end
            end
            dcp_pkg::REQ_SRE: begin
              // idle only: no open bank, no burst, cke, mode, exit and dll delays met (write wait not checked)
              if (exit_ok && !link_reg.banks_s2 && !link_reg.busy_s2 && link_reg.mod_cnt == dcp_pkg::CNT_ZERO
                  && link_reg.xs_cnt == dcp_pkg::CNT_ZERO && link_reg.dll_cnt == dcp_pkg::CNT_ZERO) begin
                link_next.pins.cke = 1'b0;
                link_next.pins.cmd = dcp_pkg::CMD_REF;
                link_next.cke_cnt  = i_timing.cke_min;
                link_next.state    = dcp_pkg::ST_SR;
              end else begin
                link_next.ref_ok = 1'b0;
              end
            end
            dcp_pkg::REQ_CMD: begin
              if (cmd_ok) begin
                link_next.pins.cmd = i_req_cmd;
                link_next.pins.odt = i_req_odt;
                if (i_req_cmd == dcp_pkg::CMD_MRS) begin
                  link_next.mod_cnt = i_timing.mod;
                end
              end else begin
                link_next.ref_ok = 1'b0;
              end
            end
            default: begin
              link_next.ref_ok = 1'b0;
            end
          endcase
        end
      end
      dcp_pkg::ST_APD, dcp_pkg::ST_PPD, dcp_pkg::ST_SR: begin
        // command pins idle while cke held low
        if (link_reg.state != dcp_pkg::ST_SR) begin
          link_next.pd_cnt = dec_cnt(link_reg.pd_cnt);
        end
        if (exit_ok && ((go && i_req_kind == dcp_pkg::REQ_EXIT)
            || (link_reg.state != dcp_pkg::ST_SR && link_reg.pd_cnt == dcp_pkg::CNT_ZERO))) begin
          if (go) begin
            link_next.req_seen = link_reg.req_s2;
            link_next.done_tgl = ~link_reg.done_tgl;
            link_next.ref_ok   = 1'b1;
          end
          link_next.pins.cke = 1'b1;
          link_next.pins.cmd = dcp_pkg::CMD_NOP;
          link_next.cke_cnt  = i_timing.cke_min;
          link_next.state    = dcp_pkg::ST_EXIT;
          if (link_reg.state == dcp_pkg::ST_SR) begin
            link_next.xs_cnt  = i_timing.xs;
            link_next.dll_cnt = i_timing.xsdll;
            link_next.wr_cnt  = dcp_pkg::WR_AFTER_SRX_NCK;
          end else begin
            link_next.xs_cnt  = i_timing.xp;
          end
        end else if (go && i_req_kind != dcp_pkg::REQ_EXIT) begin
          // anything but exit is refused while cke is low, save in the pd_max auto-exit cycle, where it is acked unrefused
          link_next.req_seen = link_reg.req_s2;
          link_next.done_tgl = ~link_reg.done_tgl;
          link_next.ref_ok   = 1'b0;
        end
      end
      dcp_pkg::ST_EXIT: begin
        link_next.state = dcp_pkg::ST_NORMAL;
      end
      default: begin
        link_next.state = dcp_pkg::ST_NORMAL;
      end
    endcase
    // flag settled state changes to the core; the exit step is skipped
    if (link_next.state != link_reg.state && link_next.state != dcp_pkg::ST_EXIT) begin
      link_next.st_tgl = ~link_reg.st_tgl;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_rstn) begin
      link_reg          <= '0;
      link_reg.state    <= dcp_pkg::ST_NORMAL;
      link_reg.pins.cmd <= dcp_pkg::CMD_DES;
      link_reg.pins.cke <= 1'b0;
    end else begin
      link_reg <= link_next;
    end
  end

  // ****************************************************
  // core domain registers
  // ****************************************************
  always_comb begin
    core_next         = core_reg;
    core_next.ack_s1  = link_reg.done_tgl;
    core_next.ack_s2  = core_reg.ack_s1;
    core_next.st_s1   = link_reg.st_tgl;
    core_next.st_s2   = core_reg.st_s1;
    // state word is stable once its toggle has passed both flops
    if (core_reg.st_s2 != core_reg.st_seen) begin
      core_next.st_seen = core_reg.st_s2;
      core_next.state   = link_reg.state;
    end
    if (core_reg.ack_s2 != core_reg.ack_seen) begin
      core_next.ack_seen = core_reg.ack_s2;
      core_next.ack_tgl  = core_reg.ack_s2;
      core_next.refused  = ~link_reg.ref_ok;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      core_reg       <= '0;
      core_reg.state <= dcp_pkg::ST_NORMAL;
    end else begin
      core_reg <= core_next;
    end
  end

  assign o_ack_tgl = core_reg.ack_tgl;
  assign o_refused = core_reg.refused;
  assign o_state   = core_reg.state;
  assign o_dram    = link_reg.pins;
  assign o_dram_ck = i_link_clk;

  // ****************************************************
  // checks
  // ****************************************************
  chk_low_cmd_idle: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    (!link_reg.pins.cke && !$past(link_reg.pins.cke)) |-> link_reg.pins.cmd == dcp_pkg::CMD_DES)
    else $error("command issued while cke held low");
  chk_cke_edge_cmd: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    ($fell(link_reg.pins.cke) && link_reg.state != dcp_pkg::ST_SR) |-> is_idle_cmd(link_reg.pins.cmd))
    else $error("power-down entry without nop");
  chk_srx_cmd_nop: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    $rose(link_reg.pins.cke) |-> is_idle_cmd(link_reg.pins.cmd))
    else $error("exit edge without nop");
  chk_xs_wait_nop: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    (link_reg.xs_cnt != dcp_pkg::CNT_ZERO) |=> is_idle_cmd(link_reg.pins.cmd))
    else $error("command inside exit delay");
  chk_sr_odt_off: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    (link_reg.state == dcp_pkg::ST_SR) |-> !link_reg.pins.odt)
    else $error("odt during self refresh");
  chk_sre_idle: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    (link_reg.pins.cmd == dcp_pkg::CMD_REF && $fell(link_reg.pins.cke))
    |-> (!$past(link_reg.banks_s2) && !$past(link_reg.busy_s2)))
    else $error("self refresh entry from non-idle");
  chk_wr_wait: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    (link_reg.pins.cmd == dcp_pkg::CMD_WR && link_reg.pins.cke) |-> $past(link_reg.wr_cnt) == dcp_pkg::CNT_ZERO)
    else $error("write before 512 cycles");
  chk_cke_hold: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    $changed(link_reg.pins.cke) |=> !$changed(link_reg.pins.cke))
    else $error("cke toggled too soon");
  chk_apd_entry: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    ($fell(link_reg.pins.cke) && link_reg.pins.cmd == dcp_pkg::CMD_NOP && $past(link_reg.banks_s2))
    |-> link_reg.state == dcp_pkg::ST_APD)
    else $error("open banks did not enter active power-down");
  chk_ppd_entry: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    ($fell(link_reg.pins.cke) && link_reg.pins.cmd == dcp_pkg::CMD_NOP && !$past(link_reg.banks_s2))
    |-> link_reg.state == dcp_pkg::ST_PPD)
    else $error("idle banks did not enter precharge power-down");
  chk_pd_auto_exit: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    ((link_reg.state == dcp_pkg::ST_APD || link_reg.state == dcp_pkg::ST_PPD)
    && link_reg.pd_cnt == dcp_pkg::CNT_ZERO && link_reg.cke_cnt == dcp_pkg::CNT_ZERO) |=> link_reg.pins.cke)
    else $error("power-down outstayed the refresh limit");
  chk_rd_dll_wait: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    (link_reg.pins.cke && (link_reg.pins.cmd == dcp_pkg::CMD_RD || link_reg.pins.odt))
    |-> $past(link_reg.dll_cnt) == dcp_pkg::CNT_ZERO)
    else $error("read or odt before dll lock delay");
  chk_pde_mod_wait: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    $fell(link_reg.pins.cke) |-> $past(link_reg.mod_cnt) == dcp_pkg::CNT_ZERO)
    else $error("cke low inside mode register delay");
  chk_state_onehot: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    $onehot(link_reg.state))
    else $error("power state not one-hot");

endmodule : dcp_ctrl

// file: bench/dcp_dram_model.sv
// behavioural ddr device watching the controller's clock-enable and command pins
`timescale 1ns/1ns
module dcp_dram_model #(
  parameter int XS = 16
) (
  input  wire logic              i_ck,
  input  wire logic              i_cke,
  input  wire logic [3:0]        i_cmd,
  input  wire logic              i_odt,
  input  wire logic              i_banks_open,
  output dcp_pkg::dcp_state_type o_state,
  output int                     o_errs
);
  logic cke_prev = 1'b0;
  int   srx_cnt  = 100000;
  logic idle_cmd;
  assign idle_cmd = i_cmd[3] || (i_cmd == dcp_pkg::CMD_NOP);
  initial o_state = dcp_pkg::ST_NORMAL;
  initial o_errs = 0;
  // odt has no effect on any transition
  always @(posedge i_ck) begin
    cke_prev <= i_cke;
    if (srx_cnt < 100000) srx_cnt <= srx_cnt + 1;
    if (cke_prev && !i_cke) begin
      if (i_cmd == dcp_pkg::CMD_REF && !i_banks_open) o_state <= dcp_pkg::ST_SR;
      else if (idle_cmd) o_state <= i_banks_open ? dcp_pkg::ST_APD : dcp_pkg::ST_PPD;
      else o_errs <= o_errs + 1;
    end else if (!cke_prev && i_cke) begin
      if (!idle_cmd) o_errs <= o_errs + 1;
      if (o_state == dcp_pkg::ST_SR) srx_cnt <= 0;
      o_state <= dcp_pkg::ST_NORMAL;
    end else if (i_cke) begin
      if ((!idle_cmd && srx_cnt < XS) || (i_cmd == dcp_pkg::CMD_WR && srx_cnt < 512)) o_errs <= o_errs + 1;
    end
    // cke held low: command pins ignored
  end
endmodule : dcp_dram_model

// file: bench/tb.sv
// self-checking bench for the clock-enable power-state controller
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic                    i_core_clk = 1'b0;
  logic                    i_link_clk = 1'b0;
  logic                    i_rstn = 1'b0;
  logic                    i_req_tgl = 1'b0;
  dcp_pkg::dcp_req_type    i_req_kind = dcp_pkg::REQ_NONE;
  logic [3:0]              i_req_cmd = 4'hF;
  logic                    i_req_odt = 1'b0;
  logic                    i_banks_open = 1'b0;
  logic                    i_busy = 1'b0;
  dcp_pkg::dcp_timing_type i_timing = '{12'h003, 12'h003, 12'h003, 12'h010, 12'h080, 12'hFFF};
  logic                    o_ack_tgl;
  logic                    o_refused;
  dcp_pkg::dcp_state_type  o_state;
  logic                    o_dram_ck;
  dcp_pkg::dcp_pins_type   o_dram;
  dcp_pkg::dcp_state_type  mdl_state;
  int                      mdl_errs;
  int                      mismatches = 0;
  int                      comparisons = 0;

  initial forever #50 i_core_clk = ~i_core_clk;
  initial begin
    #3;
    forever begin
      #7 i_link_clk = ~i_link_clk;
      #8 i_link_clk = ~i_link_clk;
    end
  end

  dcp_ctrl dcp_ctrl_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk),
    .i_req_tgl(i_req_tgl), .i_req_kind(i_req_kind), .i_req_cmd(i_req_cmd), .i_req_odt(i_req_odt),
    .i_banks_open(i_banks_open), .i_busy(i_busy), .i_timing(i_timing), .o_ack_tgl(o_ack_tgl),
    .o_refused(o_refused), .o_state(o_state), .o_dram_ck(o_dram_ck), .o_dram(o_dram));
  dcp_dram_model #(.XS(16)) dcp_dram_model_inst (.i_ck(o_dram_ck), .i_cke(o_dram.cke), .i_cmd(o_dram.cmd),
    .i_odt(o_dram.odt), .i_banks_open(i_banks_open), .o_state(mdl_state), .o_errs(mdl_errs));

  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // one request, bounded wait for its ack, refusal check unless exp_ref is x
  task automatic req(input dcp_pkg::dcp_req_type k, input logic [3:0] c, input logic exp_ref, input int gap);
    int n;
    @(posedge i_core_clk);
    i_req_kind <= k;
    i_req_cmd  <= c;
    i_req_odt  <= (c == dcp_pkg::CMD_RD);
    i_req_tgl  <= ~i_req_tgl;
    n = 0;
    @(posedge i_core_clk);
    while (o_ack_tgl !== i_req_tgl && n < 200) begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      summarize();
    end else begin
      if (exp_ref !== 1'bx) `CHK(o_refused, exp_ref)
      repeat (gap) @(posedge i_core_clk);
    end
  endtask : req

  task automatic t_power_down();
    i_banks_open <= 1'b1;
    req(dcp_pkg::REQ_PDE, 4'hF, 1'b0, 20);
    `CHK(o_state, dcp_pkg::ST_APD)
    `CHK(mdl_state, dcp_pkg::ST_APD)
    req(dcp_pkg::REQ_CMD, dcp_pkg::CMD_RD, 1'b1, 5);
    req(dcp_pkg::REQ_EXIT, 4'hF, 1'b0, 20);
    `CHK(o_state, dcp_pkg::ST_NORMAL)
    i_banks_open <= 1'b0;
    req(dcp_pkg::REQ_PDE, 4'hF, 1'b0, 20);
    `CHK(o_state, dcp_pkg::ST_PPD)
    `CHK(mdl_state, dcp_pkg::ST_PPD)
    req(dcp_pkg::REQ_EXIT, 4'hF, 1'b0, 20);
  endtask : t_power_down

  task automatic t_self_refresh();
    i_busy <= 1'b1;
    req(dcp_pkg::REQ_SRE, 4'hF, 1'b1, 5);
    i_busy <= 1'b0;
    i_banks_open <= 1'b1;
    req(dcp_pkg::REQ_SRE, 4'hF, 1'b1, 5);
    i_banks_open <= 1'b0;
    req(dcp_pkg::REQ_SRE, 4'hF, 1'b0, 20);
    `CHK(o_state, dcp_pkg::ST_SR)
    `CHK(mdl_state, dcp_pkg::ST_SR)
    req(dcp_pkg::REQ_CMD, dcp_pkg::CMD_WR, 1'b1, 5);
  endtask : t_self_refresh

  task automatic t_exit_waits();
    req(dcp_pkg::REQ_EXIT, 4'hF, 1'b0, 0);
    req(dcp_pkg::REQ_CMD, dcp_pkg::CMD_RD, 1'b1, 40);
    req(dcp_pkg::REQ_CMD, dcp_pkg::CMD_WR, 1'b1, 1);
    req(dcp_pkg::REQ_CMD, dcp_pkg::CMD_RD, 1'b0, 60);
    req(dcp_pkg::REQ_CMD, dcp_pkg::CMD_WR, 1'b0, 10);
    `CHK(o_state, dcp_pkg::ST_NORMAL)
    `CHK(mdl_errs, 0)
  endtask : t_exit_waits

  // power-down left alone must end by itself once pd_max runs out
  task automatic t_auto_exit();
    i_banks_open <= 1'b0;
    req(dcp_pkg::REQ_PDE, 4'hF, 1'b0, 20);
    `CHK(o_state, dcp_pkg::ST_PPD)
    repeat (700) @(posedge i_core_clk);
    `CHK(o_dram.cke, 1'b1)
    `CHK(mdl_state, dcp_pkg::ST_NORMAL)
    `CHK(o_state, dcp_pkg::ST_NORMAL)
    `CHK(mdl_errs, 0)
  endtask : t_auto_exit

  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    `CHK(o_dram, dcp_pkg::dcp_pins_type'({1'b1, dcp_pkg::CMD_DES, 1'b0}))
    `CHK(o_state, dcp_pkg::ST_NORMAL)
    req(dcp_pkg::REQ_EXIT, 4'hF, 1'b1, 40);
    t_power_down();
    t_self_refresh();
    t_exit_waits();
    t_auto_exit();
    summarize();
  end
endmodule : tb
